/* File: hdl/sffc_pkg.sv */
// Package: register map, field layout and reset values of the sync/forward config slice
package sffc_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_SYNC_CTL = 8'h18;
   localparam logic [7:0] IDX_HIGH_UPPER = 8'h19;
   localparam logic [7:0] IDX_HIGH_LOWER = 8'h1a;
   localparam logic [7:0] IDX_LOW_UPPER = 8'h1b;
   localparam logic [7:0] IDX_LOW_LOWER = 8'h1c;
   localparam logic [7:0] IDX_LIMIT_UPPER = 8'h1d;
   localparam logic [7:0] IDX_LIMIT_LOWER = 8'h1e;
   localparam logic [7:0] IDX_CLK_SETUP = 8'h1f;
   localparam logic [7:0] IDX_FWD_BLOCK = 8'h20;
   localparam logic [7:0] IDX_FRAME_STATE = 8'h30;
   // Reset values
   localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
   localparam logic [7:0] RST_LIMIT_LOWER = 8'h04;
   localparam logic [1:0] RST_TX_SPEED = 2'h2;
   localparam logic [3:0] RST_FWD_BLOCK = 4'hf;
   localparam logic [3:0] RST_FWD_SPARE = 4'h0;
   // Field positions
   localparam int BIT_GEN_EN = 0;
   localparam int BIT_SHAPE = 1;
   localparam int BIT_OSC_SEL = 3;
   localparam int BIT_REF_MODE = 2;
   localparam int LSB_TX_SPEED = 0;
   localparam int LSB_FWD_BLOCK = 4;
   localparam int LSB_FWD_SPARE = 0;
   localparam int BIT_TRIG_STATE = 16;
   // Transmit rate codes
   localparam logic [1:0] TX_RATE_1G5 = 2'h0;
   localparam logic [1:0] TX_RATE_RSVD = 2'h1;
   localparam logic [1:0] TX_RATE_800M = 2'h2;
   localparam logic [1:0] TX_RATE_400M = 2'h3;
   // Counter constants
   localparam logic [15:0] FRAME_NUM_ZERO = 16'h0000;
   localparam logic [15:0] FRAME_NUM_FIRST = 16'h0001;
   localparam logic [23:0] CNT_ZERO = 24'h00_0000;
   localparam logic [23:0] CNT_ONE = 24'h00_0001;
endpackage

/* File: hdl/sffc_regs.sv */
// Sync generator, frame numbering and clock/forward configuration behind Wishbone
// Operation
// - Low period is upper byte then lower byte
// - Programmed period is cycle count minus one
// - Frame limit is upper byte then lower byte
// - Frame number supplied for start and end packets
// - Limit zero keeps frame number at zero
// - Number counts from one, wraps to one
// - Select bit picks external or internal oscillator
// - Mode bit picks 200 or 100 MHz
// - Two-bit transmit rate field, reset 800 Mbps
// - Port blocks on bits 7..4, reset set
// - Half/half mode uses one 24-bit count
// - High/low mode uses separate 16-bit high count
`timescale 1ns/1ps
`default_nettype none
module sffc_regs
   import sffc_pkg::*;
#(
   parameter int AW = 10
) (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // Wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [AW-1:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Frame boundary from the packet builder
   input wire logic FRAME_START_I,
   // Generated trigger and frame number
   output logic CAMERA_TRIGGER_SIGNAL_O,
   output logic [15:0] FRAME_NUM_O,
   // Clock setup and forwarding control
   output logic INTERNAL_OSC_SELECT_O,
   output logic REF_MODE_O,
   output logic [1:0] TX_SPEED_O,
   output logic [3:0] PORT_FORWARD_BLOCK_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic gen_en;
      logic sync_shape_select;
      logic [7:0] high_hi;
      logic [7:0] high_lo;
      logic [7:0] sync_low_period_hi_byte;
      logic [7:0] sync_low_period_lo_byte;
      logic [7:0] frame_limit_hi_byte;
      logic [7:0] frame_limit_lo_byte;
      logic osc_sel;
      logic ref_mode;
      logic [1:0] tx_speed;
      logic [3:0] fwd_block;
      logic [3:0] fwd_spare;
      logic trig;
      logic [23:0] cnt;
      logic [15:0] frame_num;
   } sffc_state_t;

   sffc_state_t s_reg;
   sffc_state_t s_next;

   logic [7:0] idx;
   logic req;
   logic wr;
   logic [15:0] sync_low_period;
   logic [15:0] sync_high_period;
   logic [15:0] frame_limit;
   logic [23:0] low_per;
   logic [23:0] high_per;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and period assembly

   // New request only while no answer is out, so one access gives one ack
   assign idx = 8'(ADR_I[AW-1:2]);
   assign req = CYC_I && STB_I && !s_reg.ack;
   assign wr = req && WE_I && SEL_I[0];
   assign sync_low_period = {s_reg.sync_low_period_hi_byte, s_reg.sync_low_period_lo_byte};
   assign sync_high_period = {s_reg.high_hi, s_reg.high_lo};
   assign frame_limit = {s_reg.frame_limit_hi_byte, s_reg.frame_limit_lo_byte};

   // Half/half joins three bytes into one count for both phases
   always_comb begin
      if (s_reg.sync_shape_select) begin
         low_per = {s_reg.high_lo, sync_low_period};
         high_per = {s_reg.high_lo, sync_low_period};
      end else begin
         low_per = {8'h00, sync_low_period};
         high_per = {8'h00, sync_high_period};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;
      // Bus answer one cycle after the request, dropped the cycle after
      s_next.ack = req;
      s_next.rdata = 32'h0000_0000;
      if (req && !WE_I) begin
         case (idx)
            IDX_SYNC_CTL: begin
               s_next.rdata[BIT_GEN_EN] = s_reg.gen_en;
               s_next.rdata[BIT_SHAPE] = s_reg.sync_shape_select;
            end
            IDX_HIGH_UPPER: s_next.rdata[7:0] = s_reg.high_hi;
            IDX_HIGH_LOWER: s_next.rdata[7:0] = s_reg.high_lo;
            IDX_LOW_UPPER: s_next.rdata[7:0] = s_reg.sync_low_period_hi_byte;
            IDX_LOW_LOWER: s_next.rdata[7:0] = s_reg.sync_low_period_lo_byte;
            IDX_LIMIT_UPPER: s_next.rdata[7:0] = s_reg.frame_limit_hi_byte;
            IDX_LIMIT_LOWER: s_next.rdata[7:0] = s_reg.frame_limit_lo_byte;
            IDX_CLK_SETUP: begin
               s_next.rdata[BIT_OSC_SEL] = s_reg.osc_sel;
               s_next.rdata[BIT_REF_MODE] = s_reg.ref_mode;
               s_next.rdata[LSB_TX_SPEED +: 2] = s_reg.tx_speed;
            end
            IDX_FWD_BLOCK: begin
               s_next.rdata[LSB_FWD_BLOCK +: 4] = s_reg.fwd_block;
               s_next.rdata[LSB_FWD_SPARE +: 4] = s_reg.fwd_spare;
            end
            IDX_FRAME_STATE: begin
               s_next.rdata[15:0] = s_reg.frame_num;
               s_next.rdata[BIT_TRIG_STATE] = s_reg.trig;
            end
            default: s_next.rdata = 32'h0000_0000;
         endcase
      end
      // Byte-wide registers: only lane 0 carries data
      if (wr) begin
         case (idx)
            IDX_SYNC_CTL: begin
               s_next.gen_en = DAT_I[BIT_GEN_EN];
               s_next.sync_shape_select = DAT_I[BIT_SHAPE];
            end
            IDX_HIGH_UPPER: s_next.high_hi = DAT_I[7:0];
            IDX_HIGH_LOWER: s_next.high_lo = DAT_I[7:0];
            IDX_LOW_UPPER: s_next.sync_low_period_hi_byte = DAT_I[7:0];
            IDX_LOW_LOWER: s_next.sync_low_period_lo_byte = DAT_I[7:0];
            IDX_LIMIT_UPPER: s_next.frame_limit_hi_byte = DAT_I[7:0];
            IDX_LIMIT_LOWER: s_next.frame_limit_lo_byte = DAT_I[7:0];
            IDX_CLK_SETUP: begin
               s_next.osc_sel = DAT_I[BIT_OSC_SEL];
               s_next.ref_mode = DAT_I[BIT_REF_MODE];
               s_next.tx_speed = DAT_I[LSB_TX_SPEED +: 2];
            end
            IDX_FWD_BLOCK: begin
               s_next.fwd_block = DAT_I[LSB_FWD_BLOCK +: 4];
               s_next.fwd_spare = DAT_I[LSB_FWD_SPARE +: 4];
            end
            default: s_next.ack = req;
         endcase
      end
      // Trigger generator: while enabled, period reloads only at a phase edge; while disabled, the low count reloads every cycle
      if (!s_reg.gen_en) begin
         s_next.trig = 1'b0;
         s_next.cnt = low_per;
      end else if (s_reg.cnt == CNT_ZERO) begin
         s_next.trig = !s_reg.trig;
         s_next.cnt = s_reg.trig ? low_per : high_per;
      end else begin
         s_next.cnt = s_reg.cnt - CNT_ONE;
      end
      // Frame number moves only at frame start, held for the end packet
      if (FRAME_START_I) begin
         if (frame_limit == FRAME_NUM_ZERO) begin
            s_next.frame_num = FRAME_NUM_ZERO;
         end else if (s_reg.frame_num == FRAME_NUM_ZERO || s_reg.frame_num >= frame_limit) begin
            s_next.frame_num = FRAME_NUM_FIRST;
         end else begin
            s_next.frame_num = s_reg.frame_num + FRAME_NUM_FIRST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         s_reg <= '0;
         s_reg.frame_limit_lo_byte <= RST_LIMIT_LOWER;
         s_reg.tx_speed <= RST_TX_SPEED;
         s_reg.fwd_block <= RST_FWD_BLOCK;
         s_reg.fwd_spare <= RST_FWD_SPARE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state flops
   assign ACK_O = s_reg.ack;
   assign DAT_O = s_reg.rdata;
   assign CAMERA_TRIGGER_SIGNAL_O = s_reg.trig;
   assign FRAME_NUM_O = s_reg.frame_num;
   assign INTERNAL_OSC_SELECT_O = s_reg.osc_sel;
   assign REF_MODE_O = s_reg.ref_mode;
   assign TX_SPEED_O = s_reg.tx_speed;
   assign PORT_FORWARD_BLOCK_O = s_reg.fwd_block;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   ack_one_cycle_a: assert property (ACK_O |=> !ACK_O)
      else $error("ack held longer than one cycle");
   low_phase_load_a: assert property ($fell(s_reg.trig) |-> s_reg.cnt == $past(low_per))
      else $error("low phase loaded wrong count");
   high_phase_load_a: assert property ($rose(s_reg.trig) |-> s_reg.cnt == $past(high_per))
      else $error("high phase loaded wrong count");
   shortest_period_a: assert property (
      $fell(s_reg.trig) && s_reg.cnt == CNT_ZERO && s_reg.gen_en ##1 s_reg.gen_en
      |-> s_reg.trig)
      else $error("zero period did not last one cycle");
   count_hold_a: assert property (
      $past(s_reg.gen_en) && s_reg.gen_en && $stable(s_reg.trig)
      |-> s_reg.cnt == $past(s_reg.cnt) - CNT_ONE)
      else $error("period count reloaded mid phase");
   num_zero_a: assert property (FRAME_START_I && frame_limit == FRAME_NUM_ZERO
      |=> FRAME_NUM_O == FRAME_NUM_ZERO)
      else $error("frame number not zero with zero limit");
   num_range_a: assert property (FRAME_START_I && frame_limit != FRAME_NUM_ZERO
      |=> FRAME_NUM_O >= FRAME_NUM_FIRST && FRAME_NUM_O <= $past(frame_limit))
      else $error("frame number outside one to limit");
   num_wrap_a: assert property (FRAME_START_I && frame_limit != FRAME_NUM_ZERO
      && FRAME_NUM_O >= frame_limit |=> FRAME_NUM_O == FRAME_NUM_FIRST)
      else $error("frame number did not wrap to one");
   num_step_a: assert property (FRAME_START_I && FRAME_NUM_O != FRAME_NUM_ZERO
      && FRAME_NUM_O < frame_limit |=> FRAME_NUM_O == $past(FRAME_NUM_O) + FRAME_NUM_FIRST)
      else $error("frame number did not step by one");
   num_held_a: assert property (!FRAME_START_I |=> $stable(FRAME_NUM_O))
      else $error("frame number changed inside a frame");
   fwd_write_a: assert property (wr && idx == IDX_FWD_BLOCK
      |=> PORT_FORWARD_BLOCK_O == $past(DAT_I[7:4]))
      else $error("forward blocks not written from bits 7..4");
   clk_write_a: assert property (wr && idx == IDX_CLK_SETUP
      |=> TX_SPEED_O == $past(DAT_I[1:0]) && INTERNAL_OSC_SELECT_O == $past(DAT_I[3])
      && REF_MODE_O == $past(DAT_I[2]))
      else $error("clock setup fields not written");

   ////////////////////////////////////////////////////////////////////////////////
   // Further checks on bus answers, writes and generator loads

   // Every taken request must be answered on the next edge
   ack_after_req_a: assert property (req |=> ACK_O)
      else $error("request not answered");

   // Read data only shows with ack, so a late sampler sees zero, not stale data
   rdata_quiet_a: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
      else $error("read data outside answer cycle");

   // Disabled generator keeps the trigger low
   trig_off_a: assert property (!s_reg.gen_en |=> !CAMERA_TRIGGER_SIGNAL_O)
      else $error("trigger active while disabled");

   // Disabled generator keeps the low count loaded for a clean first phase
   idle_load_a: assert property (!s_reg.gen_en |=> s_reg.cnt == $past(low_per))
      else $error("idle count not the low period");

   // Half/half high phase uses the joined three-byte count
   half_count_a: assert property ($rose(s_reg.trig) && $past(s_reg.sync_shape_select)
      |-> s_reg.cnt == $past({s_reg.high_lo, sync_low_period}))
      else $error("half/half count not joined from three bytes");

   // High/low high phase uses only the two high bytes
   highlow_count_a: assert property ($rose(s_reg.trig) && !$past(s_reg.sync_shape_select)
      |-> s_reg.cnt == 24'($past(sync_high_period)))
      else $error("high/low high count wrong");

   // A write with lane 0 off must leave the forward blocks alone
   fwd_lane_off_a: assert property (req && WE_I && !SEL_I[0]
      |=> $stable(PORT_FORWARD_BLOCK_O))
      else $error("forward blocks changed by lane-off write");

   // Limit lower byte reads back what is stored
   read_limit_a: assert property (req && !WE_I && idx == IDX_LIMIT_LOWER
      |=> DAT_O == 32'($past(s_reg.frame_limit_lo_byte)))
      else $error("limit lower byte read back wrong");

   // Status read carries the frame number as it stood when taken
   read_status_a: assert property (req && !WE_I && idx == IDX_FRAME_STATE
      |=> DAT_O[15:0] == $past(FRAME_NUM_O))
      else $error("status read lost the frame number");

   // Clock setup moves only on its own write; a glitch here would upset the PLL
   clk_held_a: assert property (!(wr && idx == IDX_CLK_SETUP)
      |=> $stable(REF_MODE_O) && $stable(INTERNAL_OSC_SELECT_O) && $stable(TX_SPEED_O))
      else $error("clock setup changed without a write");

endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the sync generator and frame/forward config slice
`timescale 1ns/1ps
`default_nettype none
module testbench
   import sffc_pkg::*;
;
   logic clk, rst_n, cyc, stb, we, fs, ack, trig, osc, refm;
   logic [9:0] adr;
   logic [3:0] sel, fwd;
   logic [31:0] dat, dout, rd;
   logic [15:0] fnum, num, lim;
   logic [1:0] spd;
   logic [7:0] lfsr, idx, wd;
   int num_errors = 0;
   int compares = 0;
   ////////////////////////////////////////////////////////////////
   sffc_regs u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dout), .ACK_O(ack), .FRAME_START_I(fs),
      .CAMERA_TRIGGER_SIGNAL_O(trig), .FRAME_NUM_O(fnum), .INTERNAL_OSC_SELECT_O(osc),
      .REF_MODE_O(refm), .TX_SPEED_O(spd), .PORT_FORWARD_BLOCK_O(fwd));
   // Core clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // Random source, fixed start so runs repeat
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Frame number expected after one start pulse
   function automatic logic [15:0] next_num(input logic [15:0] n, input logic [15:0] l);
      if (l == 16'h0000) return 16'h0000;
      if (n == 16'h0000 || n >= l) return 16'h0001;
      return n + 16'h0001;
   endfunction
   // Register reset values
   function automatic logic [7:0] rst_val(input logic [7:0] i);
      if (i == 8'h1e) return 8'h04;
      if (i == 8'h1f) return 8'h02;
      if (i == 8'h20) return 8'hf0;
      return 8'h00;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One classic cycle; held until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] wd, input logic s0);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      dat <= {24'h00_0000, wd};
      sel <= {3'h7, s0};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         num_errors++;
         give_verdict();
      end
   endtask
   // Length of one high and one low phase; bounded so a stuck output ends the wait and shows as a mismatch
   task automatic measure(input int hi, input int lo);
      int n, h, l;
      n = 0;
      while (trig === 1'b1 && n < 600) begin @(posedge clk); n++; end
      while (trig !== 1'b1 && n < 600) begin @(posedge clk); n++; end
      h = 0;
      while (trig === 1'b1 && h < 600) begin @(posedge clk); h++; end
      l = 0;
      while (trig !== 1'b1 && l < 600) begin @(posedge clk); l++; end
      check(32'(h), 32'(hi));
      check(32'(l), 32'(lo));
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, fs} = 4'h0;
      adr = 10'h000;
      sel = 4'h0;
      dat = 32'h0000_0000;
      lfsr = 8'h07;
      num = 16'h0000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      check({26'h0, osc, refm, fwd}, 32'h0000_000f);
      check({30'h0, spd}, 32'h0000_0002);
      for (int k = 8'h1b; k <= 8'h20; k++) begin
         wb(1'b0, 8'(k), 8'h00, 1'b1);
         check(rd, {24'h00_0000, rst_val(8'(k))});
      end
      $display("test reset values done");
      // Random writes with readback and output checks
      for (int k = 0; k < 18; k++) begin
         lfsr = lfsr_next(lfsr);
         idx = 8'h1b + 8'(k % 6);
         // Software never asks for mode one at the slowest rate
         wd = (idx == IDX_CLK_SETUP && lfsr[1:0] == TX_RATE_400M) ? (lfsr & 8'hfb) : lfsr;
         wb(1'b1, idx, wd, 1'b1);
         wb(1'b0, idx, 8'h00, 1'b1);
         check(rd, {24'h0, (idx == IDX_CLK_SETUP) ? (wd & 8'h0f) : wd});
         if (idx == IDX_CLK_SETUP) check({28'h0, osc, refm, spd}, {28'h0, wd[3:0]});
         if (idx == IDX_FWD_BLOCK) check({28'h0, fwd}, {28'h0, wd[7:4]});
      end
      // Lane-off write ignored, unmapped place reads zero
      wb(1'b1, IDX_FWD_BLOCK, 8'h0f, 1'b1);
      wb(1'b1, IDX_FWD_BLOCK, 8'hf0, 1'b0);
      wb(1'b0, IDX_FWD_BLOCK, 8'h00, 1'b1);
      check(rd, 32'h0000_000f);
      check({28'h0, fwd}, 32'h0000_0000);
      wb(1'b1, 8'h25, 8'hff, 1'b1);
      wb(1'b0, 8'h25, 8'h00, 1'b1);
      check(rd, 32'h0000_0000);
      $display("test register access done");
      // Frame numbering across limit changes, zero limit and upper byte
      for (int k = 0; k < 10; k++) begin
         lim = (k < 5) ? 16'h0003 : (k < 7) ? 16'h0001 : (k < 8) ? 16'h0000 : 16'h0100;
         wb(1'b1, IDX_LIMIT_UPPER, lim[15:8], 1'b1);
         wb(1'b1, IDX_LIMIT_LOWER, lim[7:0], 1'b1);
         @(posedge clk);
         fs <= 1'b1;
         @(posedge clk);
         fs <= 1'b0;
         @(posedge clk);
         num = next_num(num, lim);
         check({16'h0, fnum}, {16'h0, num});
      end
      wb(1'b0, IDX_FRAME_STATE, 8'h00, 1'b1);
      check(rd, {16'h0, num});
      $display("test frame number done");
      // High/low shape, low count needs the upper byte
      wb(1'b1, IDX_LOW_UPPER, 8'h01, 1'b1);
      wb(1'b1, IDX_LOW_LOWER, 8'h00, 1'b1);
      wb(1'b1, IDX_HIGH_UPPER, 8'h00, 1'b1);
      wb(1'b1, IDX_HIGH_LOWER, 8'h01, 1'b1);
      wb(1'b1, IDX_SYNC_CTL, 8'h01, 1'b1);
      measure(2, 257);
      // Half/half shape, one 24-bit count for both phases
      wb(1'b1, IDX_HIGH_LOWER, 8'h00, 1'b1);
      wb(1'b1, IDX_LOW_UPPER, 8'h00, 1'b1);
      wb(1'b1, IDX_LOW_LOWER, 8'h02, 1'b1);
      wb(1'b1, IDX_SYNC_CTL, 8'h03, 1'b1);
      measure(3, 3);
      measure(3, 3);
      // Zero count gives the shortest one-cycle phases
      wb(1'b1, IDX_LOW_LOWER, 8'h00, 1'b1);
      measure(1, 1);
      $display("test generator done");
      give_verdict();
   end
endmodule
`default_nettype wire
